// [design/pvi_pkg.sv]
package pvi_pkg;
  localparam int NUM_LEVELS = 8;
  localparam int NUM_HW_LEVELS = 4;
  localparam int DEV_PER_LEVEL = 8;
  localparam int MONITOR_LEVEL = 4;
  localparam int PROG_INT_LEVEL = 3;
  localparam logic [7:0] LEVELS_RESET = 8'h00;
  localparam logic [31:0] DEV_RESET = 32'h0000_0000;
  localparam logic [3:0] SW_RESET = 4'h0;

  typedef enum logic [1:0] {
    PVI_T1,
    PVI_T2,
    PVI_T3,
    PVI_T4
  } pvi_time_t;

  // timing pulses of the i/o processor, one cycle each
  typedef struct packed {
    logic t1;
    logic t3;
    logic t4;
  } pvi_timing_t;

  // processor-side events and instructions, one cycle each
  typedef struct packed {
    logic enable_on;
    logic enable_off;
    logic monitor_call;
    logic prog_int;
    logic release_level;
    logic release_restore;
    logic cycle_start;
  } pvi_cpu_cmd_t;
endpackage

// [design/pvi_level_chain.sv]
`timescale 1ns/1ps
// daisy chain for one hardware level
module pvi_level_chain
  import pvi_pkg::*;
(
  input wire logic [DEV_PER_LEVEL-1:0] flags,
  output logic any_req,
  output logic [DEV_PER_LEVEL-1:0] winner
);
  always_comb begin
    winner = '0;
    // lowest index is nearest bus start
    for (int i = DEV_PER_LEVEL - 1; i >= 0; i--) begin
      if (flags[i]) begin
        winner = '0;
        winner[i] = 1'b1;
      end
    end
    any_req = |flags;
  end
endmodule // pvi_level_chain

// [design/pvi_unit.sv]
`timescale 1ns/1ps
module pvi_unit
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [31:0] dev_flag,
  input wire logic [3:0] sw_req,
  input wire pvi_pkg::pvi_timing_t timing,
  input wire pvi_pkg::pvi_cpu_cmd_t cmd,
  output logic facility_enabled,
  output logic cpu_request,
  output logic prog_int_disable,
  output logic cycle_sync,
  output logic grant,
  output logic [31:0] addr_enable,
  output logic [7:0] levels_active,
  output logic [7:0] requests
);
  import pvi_pkg::*;

  // ==================================================
  // input synchronisers
  logic [31:0] dev_s1_reg, dev_s2_reg;
  logic [3:0] sw_s1_reg, sw_s2_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      dev_s1_reg <= DEV_RESET;
      dev_s2_reg <= DEV_RESET;
      sw_s1_reg <= SW_RESET;
      sw_s2_reg <= SW_RESET;
    end else begin
      dev_s1_reg <= dev_flag;
      dev_s2_reg <= dev_s1_reg;
      sw_s1_reg <= sw_req;
      sw_s2_reg <= sw_s1_reg;
    end
  end

  // ==================================================
  // per-level arbitration
  logic [3:0] hw_any;
  logic [31:0] hw_win;
  genvar g;
  generate
    for (g = 0; g < NUM_HW_LEVELS; g++) begin : g_lvl
      pvi_level_chain u_chain (
        .flags(dev_s2_reg[g*DEV_PER_LEVEL +: DEV_PER_LEVEL]),
        .any_req(hw_any[g]),
        .winner(hw_win[g*DEV_PER_LEVEL +: DEV_PER_LEVEL])
      );
    end
  endgenerate

  // ==================================================
  // state
  logic enable_reg, enable_next;
  logic [7:0] rq_reg, rq_next;
  logic [7:0] pl_reg, pl_next;
  logic sync_reg, sync_next;
  logic grant_reg, grant_next;
  logic [31:0] en_reg, en_next;
  logic [2:0] lvl_reg, lvl_next;
  logic [31:0] dev_sel_reg, dev_sel_next;
  logic cpu_req_reg, cpu_req_next;
  logic pi_dis_reg, pi_dis_next;

  logic [7:0] raw_req, mask, eligible;
  logic [2:0] top_lvl, hi_pl;
  logic top_any, pl_any;

  always_comb begin
    raw_req = {sw_s2_reg, hw_any};
    // highest active level masks itself and all lower
    pl_any = 1'b0;
    hi_pl = 3'd7;
    for (int i = NUM_LEVELS - 1; i >= 0; i--) begin
      if (pl_reg[i]) begin
        pl_any = 1'b1;
        hi_pl = 3'(i);
      end
    end
    mask = '0;
    for (int i = 0; i < NUM_LEVELS; i++) begin
      mask[i] = pl_any && (3'(i) >= hi_pl);
    end
    eligible = rq_reg & ~mask;
    top_any = |eligible;
    top_lvl = 3'd0;
    for (int i = NUM_LEVELS - 1; i >= 0; i--) begin
      if (eligible[i]) top_lvl = 3'(i);
    end

    enable_next = enable_reg;
    if (cmd.enable_on) enable_next = 1'b1;
    if (cmd.enable_off) enable_next = 1'b0;

    rq_next = rq_reg;
    // clearing a flag withdraws the pending request
    rq_next = rq_reg & raw_req;
    if (timing.t4 && enable_reg && !sync_reg) begin
      rq_next = raw_req;
    end

    pl_next = pl_reg;
    if (cmd.release_level || cmd.release_restore) begin
      pl_next[hi_pl] = 1'b0;
    end
    if (cmd.monitor_call && enable_reg) pl_next[MONITOR_LEVEL] = 1'b1;
    if (cmd.prog_int) pl_next[PROG_INT_LEVEL] = 1'b1;
    if (sync_reg && timing.t4) pl_next[lvl_reg] = 1'b1;

    sync_next = sync_reg;
    lvl_next = lvl_reg;
    dev_sel_next = dev_sel_reg;
    grant_next = grant_reg;
    if (!sync_reg && cmd.cycle_start && top_any && timing.t1) begin
      sync_next = 1'b1;
      lvl_next = top_lvl;
      dev_sel_next = '0;
      if (top_lvl < 3'(NUM_HW_LEVELS)) begin
        dev_sel_next = hw_win & {NUM_HW_LEVELS{8'hFF}};
        for (int i = 0; i < NUM_HW_LEVELS; i++) begin
          if (3'(i) != top_lvl) dev_sel_next[i*DEV_PER_LEVEL +: DEV_PER_LEVEL] = 8'h00;
        end
      end
      grant_next = 1'b1;
    end
    if (sync_reg && timing.t3) grant_next = 1'b0;
    if (sync_reg && timing.t4) begin
      sync_next = 1'b0;
      rq_next[lvl_reg] = 1'b0;
    end

    en_next = en_reg;
    // entry address comes from the device
    if (grant_reg) en_next = dev_sel_reg;
    else if (timing.t1) en_next = '0;

    cpu_req_next = top_any && !sync_reg;
    pi_dis_next = |(eligible[NUM_HW_LEVELS-1:0]) || pl_reg[PROG_INT_LEVEL];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      enable_reg <= 1'b0;
      rq_reg <= LEVELS_RESET;
      pl_reg <= LEVELS_RESET;
      sync_reg <= 1'b0;
      grant_reg <= 1'b0;
      en_reg <= DEV_RESET;
      lvl_reg <= 3'd0;
      dev_sel_reg <= DEV_RESET;
      cpu_req_reg <= 1'b0;
      pi_dis_reg <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      rq_reg <= rq_next;
      pl_reg <= pl_next;
      sync_reg <= sync_next;
      grant_reg <= grant_next;
      en_reg <= en_next;
      lvl_reg <= lvl_next;
      dev_sel_reg <= dev_sel_next;
      cpu_req_reg <= cpu_req_next;
      pi_dis_reg <= pi_dis_next;
    end
  end

  assign facility_enabled = enable_reg;
  assign cpu_request = cpu_req_reg;
  assign prog_int_disable = pi_dis_reg;
  assign cycle_sync = sync_reg;
  assign grant = grant_reg;
  assign addr_enable = en_reg;
  assign levels_active = pl_reg;
  assign requests = rq_reg;

  // ==================================================
  // checks
  AST_GRANT_CLEAR: assert property (@(posedge clk) disable iff (reset)
    sync_reg && timing.t3 |=> !grant_reg) else $error("grant not cleared at time 3");
  AST_PL_SET: assert property (@(posedge clk) disable iff (reset)
    sync_reg && timing.t4 |=> pl_reg[$past(lvl_reg)]) else $error("level latch not set");
  AST_PROG_INT: assert property (@(posedge clk) disable iff (reset)
    cmd.prog_int |=> pl_reg[PROG_INT_LEVEL]) else $error("level 3 not set");
  AST_MON_CALL: assert property (@(posedge clk) disable iff (reset)
    cmd.monitor_call && enable_reg |=> pl_reg[MONITOR_LEVEL]) else $error("level 4 not set");
  AST_RQ_GATE: assert property (@(posedge clk) disable iff (reset)
    !enable_reg && !$past(enable_reg) |-> (rq_reg & ~$past(rq_reg)) == 8'h00) else $error("request set while off");
  AST_ENABLE: assert property (@(posedge clk) disable iff (reset)
    cmd.enable_off |=> !enable_reg) else $error("enable not cleared");
  AST_ADDR_ONEHOT: assert property (@(posedge clk) disable iff (reset)
    $onehot0(en_reg)) else $error("multiple address enables");
  AST_PI_DIS: assert property (@(posedge clk) disable iff (reset)
    |(eligible[3:0]) |=> pi_dis_reg) else $error("program interrupt not disabled");

  // ==================================================
  // cycle and masking checks
  AST_SYNC_CLEAR: assert property (@(posedge clk) disable iff (reset)
    sync_reg && timing.t4 |=> !sync_reg) else $error("sync not cleared at time 4");
  AST_RQ_SERVED: assert property (@(posedge clk) disable iff (reset)
    sync_reg && timing.t4 |=> !rq_reg[$past(lvl_reg)]) else $error("served request not cleared");
  AST_EN_LOAD: assert property (@(posedge clk) disable iff (reset)
    grant_reg |=> en_reg == $past(dev_sel_reg)) else $error("address enable not loaded");
  AST_EN_DROP: assert property (@(posedge clk) disable iff (reset)
    !grant_reg && timing.t1 |=> en_reg == 32'h0000_0000) else $error("address enable not dropped");
  AST_ENABLE_ON: assert property (@(posedge clk) disable iff (reset)
    cmd.enable_on && !cmd.enable_off |=> enable_reg) else $error("enable not set");
  AST_NO_REQ_IN_CYCLE: assert property (@(posedge clk) disable iff (reset)
    sync_reg |=> !cpu_req_reg) else $error("request raised during cycle");
  AST_L3_HOLD: assert property (@(posedge clk) disable iff (reset)
    pl_reg[PROG_INT_LEVEL] |=> pi_dis_reg) else $error("level 3 does not hold off interrupts");
  AST_GRANT_IN_SYNC: assert property (@(posedge clk) disable iff (reset)
    grant_reg |-> sync_reg) else $error("grant outside cycle");
  AST_RQ_WITHDRAW: assert property (@(posedge clk) disable iff (reset)
    (rq_reg & ~$past(raw_req)) == 8'h00) else $error("request kept without source");
  AST_TOP_MASK: assert property (@(posedge clk) disable iff (reset)
    pl_reg[0] |-> eligible == 8'h00) else $error("level 0 active but request eligible");
endmodule // pvi_unit

// [sim/pvi_proc_model.sv]
`timescale 1ns/1ps
// ==========
// processor and i/o timing side
module pvi_proc_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic cpu_request,
  output pvi_pkg::pvi_timing_t timing,
  output logic cycle_start
);
  import pvi_pkg::*;
  logic [1:0] phase_reg;
  logic armed_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_reg <= 2'h0;
      armed_reg <= 1'b0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      if (phase_reg == 2'h3) armed_reg <= cpu_request && !armed_reg;
    end
  end
  // t1, t3, t4 in fixed order, one cycle each
  assign timing.t1 = (phase_reg == 2'h0);
  assign timing.t3 = (phase_reg == 2'h2);
  assign timing.t4 = (phase_reg == 2'h3);
  // slow answer waits until the request has been seen at a t4
  assign cycle_start = timing.t1 && cpu_request && (!slow || armed_reg);
endmodule // pvi_proc_model

// [sim/priority_vectored_interrupt_unit_tb.sv]
`timescale 1ns/1ps
module priority_vectored_interrupt_unit_tb;
  import pvi_pkg::*;
  typedef struct {logic [31:0] dev; logic [3:0] sw; logic [31:0] addr; logic [7:0] lvl;} pvi_row_t;
  logic clk, reset, slow, cs, facility_enabled, cpu_request, prog_int_disable, cycle_sync, grant;
  logic [31:0] dev_flag, addr_enable;
  logic [3:0] sw_req;
  logic [7:0] levels_active, requests;
  pvi_timing_t timing;
  pvi_cpu_cmd_t cmd_b, cmd_w;
  int mismatches = 0;
  int cmp_count = 0;
  // at most eight devices a level, fixed slots
  pvi_row_t rows[5] = '{'{32'h0000_0100, 4'h0, 32'h0000_0100, 8'h02},
    '{32'h0000_0C00, 4'h0, 32'h0000_0400, 8'h02}, '{32'h8000_0001, 4'h0, 32'h0000_0001, 8'h01},
    '{32'h0000_0000, 4'h4, 32'h0000_0000, 8'h40}, '{32'h0100_0000, 4'h1, 32'h0100_0000, 8'h08}};
  always_comb begin
    cmd_w = cmd_b;
    cmd_w.cycle_start = cs;
  end
  pvi_unit dut_u (.clk(clk), .reset(reset), .dev_flag(dev_flag), .sw_req(sw_req), .timing(timing),
    .cmd(cmd_w), .facility_enabled(facility_enabled), .cpu_request(cpu_request),
    .prog_int_disable(prog_int_disable), .cycle_sync(cycle_sync), .grant(grant),
    .addr_enable(addr_enable), .levels_active(levels_active), .requests(requests));
  pvi_proc_model model_u (.clk(clk), .reset(reset), .slow(slow), .cpu_request(cpu_request),
    .timing(timing), .cycle_start(cs));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ==========
  // shared tasks
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic pulse(input logic [6:0] c);
    cmd_b = c;
    @(negedge clk);
    cmd_b = 7'h00;
    @(negedge clk);
  endtask
  task automatic wait_on(input bit want_req);
    for (int i = 0; i < 300 && (want_req ? cpu_request : grant) !== 1'b1; i++) @(negedge clk);
    if ((want_req ? cpu_request : grant) !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
  endtask
  task automatic serve(input logic [31:0] addr, input logic [7:0] lvl);
    wait_on(1'b0);
    chk("cycle_sync", {31'h0, cycle_sync}, 32'h1);
    @(negedge clk);
    chk("addr_enable", addr_enable, addr);
    @(negedge clk);
    chk("grant", {31'h0, grant}, 32'h0);
    @(negedge clk);
    chk("levels_active", {24'h0, levels_active}, {24'h0, lvl});
    chk("cycle_sync_end", {31'h0, cycle_sync}, 32'h0);
  endtask
  task automatic drop_and_release(input logic [7:0] lvl);
    dev_flag = 32'h0;
    sw_req = 4'h0;
    repeat (4) @(negedge clk);
    pulse(7'h04);
    chk("released", {24'h0, levels_active}, {24'h0, lvl});
  endtask
  // ==========
  // main sequence
  initial begin
    reset = 1'b1;
    slow = 1'b0;
    dev_flag = 32'h0;
    sw_req = 4'h0;
    cmd_b = 7'h00;
    repeat (5) @(negedge clk);
    chk("reset_levels", {24'h0, levels_active}, 32'h0);
    chk("reset_enable", {31'h0, facility_enabled}, 32'h0);
    $display("reset test done");
    reset = 1'b0;
    pulse(7'h40);
    chk("enable", {31'h0, facility_enabled}, 32'h1);
    foreach (rows[i]) begin
      slow = i[0];
      dev_flag = rows[i].dev;
      sw_req = rows[i].sw;
      serve(rows[i].addr, rows[i].lvl);
      drop_and_release(8'h00);
      $display("row %0d done", i);
    end
    // disabled: nothing latches, program interrupt still sets level 3
    pulse(7'h20);
    dev_flag = 32'h0000_0001;
    repeat (40) @(negedge clk);
    chk("requests_off", {24'h0, requests}, 32'h0);
    chk("cpu_request_off", {31'h0, cpu_request}, 32'h0);
    dev_flag = 32'h0;
    pulse(7'h08);
    chk("prog_int_level", {24'h0, levels_active}, 32'h08);
    chk("prog_int_disable", {31'h0, prog_int_disable}, 32'h1);
    $display("disabled test done");
    pulse(7'h40);
    sw_req = 4'h1;
    repeat (40) @(negedge clk);
    chk("held_off", {31'h0, cpu_request}, 32'h0);
    pulse(7'h02);
    serve(32'h0, 8'h10);
    drop_and_release(8'h00);
    $display("masking test done");
    pulse(7'h10);
    chk("monitor_call", {24'h0, levels_active}, 32'h10);
    slow = 1'b1;
    dev_flag = 32'h0001_0000;
    wait_on(1'b1);
    chk("hw_disables_pi", {31'h0, prog_int_disable}, 32'h1);
    serve(32'h0001_0000, 8'h14);
    drop_and_release(8'h10);
    pulse(7'h04);
    chk("all_released", {24'h0, levels_active}, 32'h0);
    $display("preempt test done");
    wrap_up();
  end
endmodule // priority_vectored_interrupt_unit_tb
